// ===== common/link_status_pkg.sv
// constants shared by the sensor-link status bank
package link_status_pkg;

  // ===========================
  // register addresses (6-bit serial-port address space)
  localparam logic [5:0] FAULT_STATUS_ONE_ADDR     = 6'h04;
  localparam logic [5:0] CHANNEL_FAULT_STATUS_ADDR = 6'h05;
  localparam logic [5:0] LIVE_STATE_STATUS_ADDR    = 6'h06;
  localparam logic [5:0] LAST_VALID_ADDR           = 6'h1F;

  // ===========================
  // serial frame layout
  localparam int         FRAME_BITS     = 32;
  localparam logic [5:0] FRAME_BITS_CNT = 6'h20;
  localparam int         FRM_WRITE_POS  = 31;
  localparam int         FRM_ADDR_MSB   = 30;
  localparam int         FRM_ADDR_LSB   = 25;
  localparam int         FRM_CRC_MSB    = 2;
  localparam int         FRM_CRC_BODY   = 29;
  localparam logic [2:0] CRC_SEED       = 3'h5;
  localparam logic [2:0] CRC_POLY       = 3'h3;

  // ===========================
  // fault_status_one bit positions
  localparam int SR1_DONE      = 15;
  localparam int SR1_ABORTED   = 14;
  localparam int SR1_RUNNING   = 13;
  localparam int SR1_SERIAL_PORT_FAULT   = 12;
  localparam int SR1_TRIM_ERR  = 11;
  localparam int SR1_REG_UV    = 10;
  localparam int SR1_REG_OV    = 9;
  localparam int SR1_REG_DEEP  = 8;
  localparam int SR1_CH2_LSB   = 4;
  localparam int SR1_CH1_LSB   = 0;
  // per-channel nibble in fault_status_one
  localparam int SYN_TIMEOUT   = 3;
  localparam int SYN_UPBUF     = 2;
  localparam int SYN_SLOW      = 1;
  localparam int SYN_LOW       = 0;

  // ===========================
  // channel_fault_status: channel 2 in the upper byte
  localparam int SR2_CH2_LSB   = 8;
  localparam int SR2_CH1_LSB   = 0;
  localparam int LF_XCT_RESULT = 7;
  localparam int LF_BUF_EMPTY  = 6;
  localparam int LF_OPEN_LOAD  = 5;
  localparam int LF_SHORT_BAT  = 4;
  localparam int LF_LEAKAGE    = 3;
  localparam int LF_SHORT_GND  = 2;
  localparam int LF_OVERTEMP   = 1;
  localparam int LF_UNDERVOLT  = 0;
  localparam logic [7:0] LF_READ_CLEAR = 8'hF9;
  localparam logic [7:0] LF_XCT_MASKED = 8'hEE;

  // ===========================
  // live_state_status bit positions
  localparam int SR3_SELFTEST  = 15;
  localparam int SR3_INIT_RDY  = 14;
  localparam int SR3_REG_ON    = 13;
  localparam int SR3_FIFO_LOCKED  = 12;
  localparam int SR3_CH2_LSB   = 7;
  localparam int SR3_CH1_LSB   = 3;
  localparam int LS_PIN_LEVEL  = 2;
  localparam int LS_PENDING    = 1;
  localparam int LS_ACTIVE     = 0;
  localparam int SR3_CLOCK_FAULT_RESET_FLAG   = 1;
  localparam int SR3_RESET     = 0;

  // ===========================
  // timing
  localparam int MCLK_PERIOD_NS    = 100;
  localparam int SYNC_TIMEOUT_NS   = 100000;
  localparam int SYNC_TIMEOUT_CYC  = (SYNC_TIMEOUT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int PIN_FILTER_NS     = 10000;
  localparam int PIN_FILTER_CYC    = (PIN_FILTER_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

endpackage

// ===== hdl/sync_pin_monitor.sv
// high-time monitor for one sync input pin
`timescale 1ns/10ps
module sync_pin_monitor
  import link_status_pkg::*;
#(
  parameter int TIMEOUT_CYC = SYNC_TIMEOUT_CYC,
  parameter int FILTER_CYC  = PIN_FILTER_CYC,
  parameter int CNT_W       = 11
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // pin and mode
  input  wire logic pin_i,
  input  wire logic pin_source_i,
  // event pulses
  output logic      timeout_o,
  output logic      filtered_high_o
);

  // ===========================
  // pin synchroniser
  logic             pin_meta_r;
  logic             pin_sync_r;
  logic [CNT_W-1:0] high_cnt_r;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ===========================
  // high-time counter, saturates so a stuck pin reports once per episode
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_cnt_r <= '0;
    end else if (!pin_sync_r) begin
      high_cnt_r <= '0;
    end else if (high_cnt_r != CNT_W'(TIMEOUT_CYC)) begin
      high_cnt_r <= high_cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timeout_o       <= 1'b0;
      filtered_high_o <= 1'b0;
    end else begin
      timeout_o       <= pin_sync_r && pin_source_i
                         && (high_cnt_r == CNT_W'(TIMEOUT_CYC - 1)); // R7
      filtered_high_o <= pin_sync_r && (high_cnt_r == CNT_W'(FILTER_CYC - 1)); // R18
    end
  end

endmodule

// ===== hdl/sensor_link_status_bank.sv
// status register bank of the two-channel sensor-link transceiver
//
// Behaviour
// R1: status one and two flags latch on their condition and clear when read.
// R2: status one bits 15/14 latch test done/aborted; bit 13 shows test running.
// R3: bit 12 sets on frame CRC error, bad clock count, sensor read fault, bad address.
// R4: bit 11 shows trimming-memory CRC failure live, never latched.
// R5: bit 10 latches regulator undervoltage; bit 9 shows overvoltage live.
// R6: deep undervoltage switches regulator off; bit 8 clears only on enable written 0.
// R7: pin-driven sync held active over 100 us flags timeout, bits 7 and 3.
// R8: writing a busy upstream buffer sets buffer fault, bits 6 and 2.
// R9: missing, late or weak sync pulse sets slow flag, bits 5 and 1.
// R10: sync pulse below threshold beyond filter time sets bits 4 and 0.
// R11: status two holds eight fault bits per channel, channel two on top.
// R12: short-to-ground and overtemperature clear only on channel enable written 0.
// R13: during cross test, short-battery and undervoltage are kept out of summary.
// R14: undervoltage bit is live normally, carries cross-test ground result during test.
// R15: status three bit 15 shows self-test registers writable.
// R16: bit 14 shows init data ready, bit 13 regulator enabled.
// R17: FIFO lock sets on first read after full, clears when empty.
// R18: sync pin bits set when pin high beyond filter time, clear on read.
// R19: buffer pending bits follow buffer busy, not cleared by reading.
// R20: channel state bits show channel enabled.
// R21: bit 1 latches reset by clock fault, clears on read.
// R22: bit 0 sets after any reset, clears on read; here set by reset_n_i and soft reset only, not by clock-fault reset.
// R23: host reaches registers over four-wire serial port.
// R24: read-clear registers return contents, then clear their clearable bits.
// R25: reserved bits read zero, writes ignored.
// R26: event in the clearing cycle survives the read.
`timescale 1ns/10ps
module sensor_link_status_bank
  import link_status_pkg::*;
#(
  parameter int TIMEOUT_CYC = SYNC_TIMEOUT_CYC,
  parameter int FILTER_CYC  = PIN_FILTER_CYC
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // serial register port
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_o,
  // cross-coupling test
  input  wire logic       crosscouple_done_i,
  input  wire logic       crosscouple_aborted_i,
  input  wire logic       crosscouple_running_i,
  // device health
  input  wire logic       trim_crc_fail_i,
  input  wire logic       sensor_read_fault_i,
  input  wire logic       clock_fault_reset_i,
  input  wire logic       soft_reset_i,
  // supply regulator
  input  wire logic       supply_reg_undervolt_i,
  input  wire logic       supply_reg_overvolt_i,
  input  wire logic       supply_reg_deep_undervolt_i,
  input  wire logic       supply_reg_enable_bit_i,
  input  wire logic       supply_reg_enable_wr_i,
  input  wire logic       supply_reg_active_i,
  output logic            supply_reg_off_o,
  // per channel, index 0 is channel one
  input  wire logic [1:0] sync_pin_i,
  input  wire logic [1:0] sync_pin_source_i,
  input  wire logic [1:0] sync_slow_i,
  input  wire logic [1:0] sync_low_level_i,
  input  wire logic [1:0] upbuf_write_i,
  input  wire logic [1:0] upbuf_pending_i,
  input  wire logic [1:0] ch_enable_bit_i,
  input  wire logic       ch_enable_wr_i,
  // per-channel line faults
  input  wire logic [1:0] crosscouple_result_i,
  input  wire logic [1:0] buffer_empty_fault_i,
  input  wire logic [1:0] open_load_i,
  input  wire logic [1:0] short_battery_i,
  input  wire logic [1:0] ground_leakage_i,
  input  wire logic [1:0] short_ground_i,
  input  wire logic [1:0] overtemp_i,
  input  wire logic [1:0] line_undervolt_i,
  input  wire logic [1:0] xct_ground_result_i,
  // misc live state
  input  wire logic       selftest_write_allowed_i,
  input  wire logic       sensor_init_ready_i,
  input  wire logic       fifo_full_i,
  input  wire logic       fifo_empty_i,
  input  wire logic       fifo_read_i,
  // summary
  output logic            global_fault_summary_o
);

  // ===========================
  // functions
  function automatic logic [2:0] frame_crc(input logic [FRM_CRC_BODY-1:0] body);
    logic [2:0] c;
    logic       fb;
    c = CRC_SEED;
    for (int i = FRM_CRC_BODY - 1; i >= 0; i--) begin
      fb = c[2] ^ body[i];
      c  = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
    end
    return c;
  endfunction

  // ===========================
  // declarations
  logic        cs_meta_r, cs_sync_r, cs_old_r;
  logic        sclk_meta_r, sclk_sync_r, sclk_old_r;
  logic        mosi_meta_r, mosi_sync_r;
  logic [31:0] rx_sr_r;
  logic [31:0] tx_sr_r;
  logic [5:0]  bit_cnt_r;
  logic [15:0] rd_data_r;
  logic        clr_one_r, clr_two_r, clr_three_r;
  logic        spi_fault_r;
  logic [15:0] sr1_lat_r;
  logic [15:0] sr2_lat_r;
  logic [1:0]  pin_level_r;
  logic        fifo_lock_r;
  logic        clk_fault_r;
  logic        reset_seen_r;
  logic [1:0]  pin_timeout;
  logic [1:0]  pin_high;
  logic        frame_start, frame_end, sclk_rise, sclk_fall;
  logic [5:0]  frame_addr;
  logic        frame_ok;
  logic [15:0] sr1_val, sr2_val, sr3_val, rd_mux;
  logic [15:0] sr1_set, sr2_set, sr2_clr;
  logic [15:0] summary_mask;

  // ===========================
  // sync pin monitors
  for (genvar ch = 0; ch < 2; ch++) begin : g_pin
    sync_pin_monitor #(
      .TIMEOUT_CYC (TIMEOUT_CYC),
      .FILTER_CYC  (FILTER_CYC)
    ) u_mon (
      .mclk_i          (mclk_i),
      .reset_n_i       (reset_n_i),
      .pin_i           (sync_pin_i[ch]),
      .pin_source_i    (sync_pin_source_i[ch]),
      .timeout_o       (pin_timeout[ch]),
      .filtered_high_o (pin_high[ch])
    );
  end

  // ===========================
  // serial port synchronisers; host sclk must stay well below mclk / 4
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_meta_r   <= 1'b1;
      cs_sync_r   <= 1'b1;
      cs_old_r    <= 1'b1;
      sclk_meta_r <= 1'b0;
      sclk_sync_r <= 1'b0;
      sclk_old_r  <= 1'b0;
      mosi_meta_r <= 1'b0;
      mosi_sync_r <= 1'b0;
    end else begin
      cs_meta_r   <= spi_cs_n_i;
      cs_sync_r   <= cs_meta_r;
      cs_old_r    <= cs_sync_r;
      sclk_meta_r <= spi_sclk_i;
      sclk_sync_r <= sclk_meta_r;
      sclk_old_r  <= sclk_sync_r;
      mosi_meta_r <= spi_mosi_i;
      mosi_sync_r <= mosi_meta_r;
    end
  end

  assign frame_start = cs_old_r && !cs_sync_r;
  assign frame_end   = !cs_old_r && cs_sync_r;
  assign sclk_rise   = !cs_sync_r && sclk_sync_r && !sclk_old_r;
  assign sclk_fall   = !cs_sync_r && !sclk_sync_r && sclk_old_r;
  assign frame_addr  = rx_sr_r[FRM_ADDR_MSB:FRM_ADDR_LSB];
  assign frame_ok    = (bit_cnt_r == FRAME_BITS_CNT)
                       && (frame_crc(rx_sr_r[FRAME_BITS-1:FRM_CRC_MSB+1])
                           == rx_sr_r[FRM_CRC_MSB:0])
                       && (frame_addr <= LAST_VALID_ADDR); // R3

  // ===========================
  // frame shifter: answer to a read goes out in the following frame
  always_ff @(posedge mclk_i or negedge reset_n_i) begin // R23
    if (!reset_n_i) begin
      rx_sr_r   <= '0;
      tx_sr_r   <= '0;
      bit_cnt_r <= '0;
    end else if (frame_start) begin
      bit_cnt_r <= '0;
      tx_sr_r   <= {rd_data_r, 16'h0000};
    end else begin
      if (sclk_rise) begin
        rx_sr_r <= {rx_sr_r[FRAME_BITS-2:0], mosi_sync_r};
        if (bit_cnt_r != 6'h3F) begin
          bit_cnt_r <= bit_cnt_r + 6'h01;
        end
      end
      if (sclk_fall) begin
        tx_sr_r <= {tx_sr_r[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= !cs_sync_r;
      if (frame_start) begin
        spi_miso_o <= rd_data_r[15];
      end else if (sclk_fall) begin
        spi_miso_o <= tx_sr_r[FRAME_BITS-2];
      end
    end
  end

  // ===========================
  // frame completion: snapshot and clear strobes land on the same edge
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_r   <= '0;
      clr_one_r   <= 1'b0;
      clr_two_r   <= 1'b0;
      clr_three_r <= 1'b0;
      spi_fault_r <= 1'b0;
    end else begin
      clr_one_r   <= 1'b0;
      clr_two_r   <= 1'b0;
      clr_three_r <= 1'b0;
      spi_fault_r <= frame_end && !frame_ok; // R3
      if (frame_end && frame_ok && !rx_sr_r[FRM_WRITE_POS]) begin
        rd_data_r   <= rd_mux; // R24
        clr_one_r   <= (frame_addr == FAULT_STATUS_ONE_ADDR);
        clr_two_r   <= (frame_addr == CHANNEL_FAULT_STATUS_ADDR);
        clr_three_r <= (frame_addr == LIVE_STATE_STATUS_ADDR);
      end
    end
  end

  // writes to status registers have no target: R25
  always_comb begin
    unique case (frame_addr)
      FAULT_STATUS_ONE_ADDR:     rd_mux = sr1_val;
      CHANNEL_FAULT_STATUS_ADDR: rd_mux = sr2_val;
      LIVE_STATE_STATUS_ADDR:    rd_mux = sr3_val;
      default:                   rd_mux = 16'h0000;
    endcase
  end

  // ===========================
  // fault_status_one
  always_comb begin
    sr1_set                              = '0;
    sr1_set[SR1_DONE]                    = crosscouple_done_i; // R2
    sr1_set[SR1_ABORTED]                 = crosscouple_aborted_i; // R2
    sr1_set[SR1_SERIAL_PORT_FAULT]                 = spi_fault_r || sensor_read_fault_i; // R3
    sr1_set[SR1_REG_UV]                  = supply_reg_undervolt_i; // R5
    sr1_set[SR1_REG_DEEP]                = supply_reg_deep_undervolt_i; // R6
    sr1_set[SR1_CH2_LSB+SYN_TIMEOUT]     = pin_timeout[1]; // R7
    sr1_set[SR1_CH1_LSB+SYN_TIMEOUT]     = pin_timeout[0]; // R7
    sr1_set[SR1_CH2_LSB+SYN_UPBUF]       = upbuf_write_i[1] && upbuf_pending_i[1]; // R8
    sr1_set[SR1_CH1_LSB+SYN_UPBUF]       = upbuf_write_i[0] && upbuf_pending_i[0]; // R8
    sr1_set[SR1_CH2_LSB+SYN_SLOW]        = sync_slow_i[1]; // R9
    sr1_set[SR1_CH1_LSB+SYN_SLOW]        = sync_slow_i[0]; // R9
    sr1_set[SR1_CH2_LSB+SYN_LOW]         = sync_low_level_i[1]; // R10
    sr1_set[SR1_CH1_LSB+SYN_LOW]         = sync_low_level_i[0]; // R10
  end

  // deep-undervolt flag ignores reads; only an enable write of zero drops it
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sr1_lat_r <= '0;
    end else begin
      for (int b = 0; b < 16; b++) begin
        if (sr1_set[b]) begin
          sr1_lat_r[b] <= 1'b1; // R26
        end else if (b == SR1_REG_DEEP) begin
          if (supply_reg_enable_wr_i && !supply_reg_enable_bit_i) begin
            sr1_lat_r[b] <= 1'b0; // R6
          end
        end else if (clr_one_r) begin
          sr1_lat_r[b] <= 1'b0; // R1
        end
      end
    end
  end

  always_comb begin
    sr1_val               = sr1_lat_r;
    sr1_val[SR1_RUNNING]  = crosscouple_running_i; // R2
    sr1_val[SR1_TRIM_ERR] = trim_crc_fail_i; // R4
    sr1_val[SR1_REG_OV]   = supply_reg_overvolt_i; // R5
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      supply_reg_off_o <= 1'b0;
    end else begin
      supply_reg_off_o <= sr1_lat_r[SR1_REG_DEEP] || supply_reg_deep_undervolt_i; // R6
    end
  end

  // ===========================
  // channel_fault_status
  always_comb begin
    sr2_set = '0;
    sr2_clr = '0;
    for (int ch = 0; ch < 2; ch++) begin
      sr2_set[ch*8+LF_XCT_RESULT] = crosscouple_result_i[ch]; // R11
      sr2_set[ch*8+LF_BUF_EMPTY]  = buffer_empty_fault_i[ch];
      sr2_set[ch*8+LF_OPEN_LOAD]  = open_load_i[ch];
      sr2_set[ch*8+LF_SHORT_BAT]  = short_battery_i[ch];
      sr2_set[ch*8+LF_LEAKAGE]    = ground_leakage_i[ch];
      sr2_set[ch*8+LF_SHORT_GND]  = short_ground_i[ch];
      sr2_set[ch*8+LF_OVERTEMP]   = overtemp_i[ch];
      sr2_set[ch*8+LF_UNDERVOLT]  = crosscouple_running_i && xct_ground_result_i[ch]; // R14
      sr2_clr[ch*8 +: 8]          = clr_two_r ? LF_READ_CLEAR : 8'h00; // R1
      if (ch_enable_wr_i && !ch_enable_bit_i[ch]) begin
        sr2_clr[ch*8+LF_SHORT_GND] = 1'b1; // R12
        sr2_clr[ch*8+LF_OVERTEMP]  = 1'b1; // R12
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sr2_lat_r <= '0;
    end else begin
      sr2_lat_r <= (sr2_lat_r & ~sr2_clr) | sr2_set; // R26
    end
  end

  always_comb begin
    sr2_val = sr2_lat_r;
    if (!crosscouple_running_i) begin
      sr2_val[SR2_CH2_LSB+LF_UNDERVOLT] = line_undervolt_i[1]; // R14
      sr2_val[SR2_CH1_LSB+LF_UNDERVOLT] = line_undervolt_i[0]; // R14
    end
  end

  // short-battery and undervolt hidden from the summary while the test runs
  assign summary_mask = crosscouple_running_i ? {LF_XCT_MASKED, LF_XCT_MASKED}
                                              : 16'hFFFF;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      global_fault_summary_o <= 1'b0;
    end else begin
      global_fault_summary_o <= |(sr2_val & summary_mask); // R13
    end
  end

  // ===========================
  // live_state_status latched bits
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_level_r  <= '0;
      clk_fault_r  <= 1'b0;
      reset_seen_r <= 1'b1; // R22
    end else begin
      pin_level_r  <= (pin_level_r & ~{2{clr_three_r}}) | pin_high; // R18
      clk_fault_r  <= (clk_fault_r && !clr_three_r) || clock_fault_reset_i; // R21
      reset_seen_r <= (reset_seen_r && !clr_three_r) || soft_reset_i; // R22
    end
  end

  // empty wins: a drained FIFO can never stay locked
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fifo_lock_r <= 1'b0;
    end else if (fifo_empty_i) begin
      fifo_lock_r <= 1'b0; // R17
    end else if (fifo_read_i && fifo_full_i) begin
      fifo_lock_r <= 1'b1; // R17
    end
  end

  always_comb begin
    sr3_val                            = 16'h0000; // R25
    sr3_val[SR3_SELFTEST]              = selftest_write_allowed_i; // R15
    sr3_val[SR3_INIT_RDY]              = sensor_init_ready_i; // R16
    sr3_val[SR3_REG_ON]                = supply_reg_active_i; // R16
    sr3_val[SR3_FIFO_LOCKED]              = fifo_lock_r;
    sr3_val[SR3_CH2_LSB+LS_PIN_LEVEL]  = pin_level_r[1];
    sr3_val[SR3_CH1_LSB+LS_PIN_LEVEL]  = pin_level_r[0];
    sr3_val[SR3_CH2_LSB+LS_PENDING]    = upbuf_pending_i[1]; // R19
    sr3_val[SR3_CH1_LSB+LS_PENDING]    = upbuf_pending_i[0]; // R19
    sr3_val[SR3_CH2_LSB+LS_ACTIVE]     = ch_enable_bit_i[1]; // R20
    sr3_val[SR3_CH1_LSB+LS_ACTIVE]     = ch_enable_bit_i[0]; // R20
    sr3_val[SR3_CLOCK_FAULT_RESET_FLAG]               = clk_fault_r;
    sr3_val[SR3_RESET]                 = reset_seen_r;
  end

endmodule

// ===== test/link_status_props.sv
// port-level checks for the sensor-link status bank
`timescale 1ns/10ps
module link_status_props (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       reset_n_i,
  // watched ports
  input wire logic       spi_cs_n_i,
  input wire logic       spi_miso_oe_o,
  input wire logic       supply_reg_deep_undervolt_i,
  input wire logic       supply_reg_enable_bit_i,
  input wire logic       supply_reg_enable_wr_i,
  input wire logic       supply_reg_off_o,
  input wire logic       crosscouple_running_i,
  input wire logic [1:0] overtemp_i,
  input wire logic [1:0] line_undervolt_i,
  input wire logic       global_fault_summary_o
);
  // ===========================
  // properties
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic clr;
  assign clr = supply_reg_enable_wr_i && !supply_reg_enable_bit_i;
  // off may trail the flag by a register
  sequence s_hold; !clr ##1 (supply_reg_off_o && !clr); endsequence
  sequence s_release; (clr && !supply_reg_deep_undervolt_i) ##1 !supply_reg_deep_undervolt_i[*3];
  endsequence
  property p_oe_on; $fell(spi_cs_n_i) |-> ##[1:4] spi_miso_oe_o; endproperty
  property p_oe_off; spi_cs_n_i[*4] |-> !spi_miso_oe_o; endproperty
  property p_deep_off; supply_reg_deep_undervolt_i |-> ##[1:3] supply_reg_off_o; endproperty
  property p_off_hold; s_hold |=> supply_reg_off_o; endproperty
  property p_off_clear; s_release |-> !supply_reg_off_o; endproperty
  property p_ot_sum; |overtemp_i |-> ##[1:4] global_fault_summary_o; endproperty
  property p_uv_sum; (!crosscouple_running_i && |line_undervolt_i)[*4] |-> global_fault_summary_o;
  endproperty
  property p_rst_val; $rose(reset_n_i) |-> !supply_reg_off_o && !global_fault_summary_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso enable late");
  a_oe_off: assert property (p_oe_off) else $error("miso enable idle");
  a_deep_off: assert property (p_deep_off) else $error("regulator not off");
  a_off_hold: assert property (p_off_hold) else $error("regulator off dropped");
  a_off_clear: assert property (p_off_clear) else $error("regulator off stuck");
  a_ot_sum: assert property (p_ot_sum) else $error("summary missed");
  a_uv_sum: assert property (p_uv_sum) else $error("summary missed live");
  a_rst_val: assert property (p_rst_val) else $error("reset values");
endmodule

bind sensor_link_status_bank link_status_props chk_i (.*);

// ===== test/spi_host_model.sv
// host-side serial port model for 32-bit frames
`timescale 1ns/10ps
module spi_host_model (
  // clock
  input  wire logic mclk_i,
  // serial lines
  input  wire logic spi_miso_i,
  output logic      spi_cs_n_o,
  output logic      spi_sclk_o,
  output logic      spi_mosi_o
);
  // ===========================
  // frame transfer, msb first, 4 clocks per sclk phase
  initial {spi_cs_n_o, spi_sclk_o, spi_mosi_o} = 3'h4;
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    @(posedge mclk_i) #1 {spi_cs_n_o, spi_mosi_o} = {1'b0, tx[31]};
    for (int i = 31; i >= 0; i--) begin
      repeat (4) @(posedge mclk_i);
      #1 spi_sclk_o = 1'b1;
      rx[i] = spi_miso_i;
      repeat (4) @(posedge mclk_i);
      #1 spi_sclk_o = 1'b0;
      // idle data shows the inverse
      spi_mosi_o = (i > 0) ? tx[i-1] : ~tx[0];
    end
    repeat (4) @(posedge mclk_i);
    #1 spi_cs_n_o = 1'b1;
    repeat (8) @(posedge mclk_i);
    #1;
  endtask
endmodule

// ===== test/test_sensor_link_status_bank.sv
// self-checking bench for the sensor-link status bank
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module test_sensor_link_status_bank;
  import link_status_pkg::*;
  logic        mclk_i, reset_n_i, cs_n, sclk, mosi, miso, sum;
  logic        run, trim, ov, sel, init, supply_reg_active, en_bit, en_wr, ch_wr, full, empty, fread;
  logic [1:0]  pin, src, pend, chen, uv, xg;
  logic [16:0] ev;
  logic [15:0] lf;
  logic [15:0] keep [8] = '{default: 16'h0000};
  int          err_total = 0;
  int          checked = 0;
  // ===========================
  // event table: sticky nibble, address nibble, expected mask
  logic [23:0] tbl [17] = '{24'h048000, 24'h044000, 24'h041000, 24'h040400, 24'h040022,
    24'h040011, 24'h040044, 24'h060002, 24'h060001, 24'h058080, 24'h054040, 24'h052020,
    24'h051010, 24'h050808, 24'h140100, 24'h150404, 24'h150202};
  spi_host_model host (.mclk_i(mclk_i), .spi_miso_i(miso), .spi_cs_n_o(cs_n),
    .spi_sclk_o(sclk), .spi_mosi_o(mosi));
  sensor_link_status_bank #(.TIMEOUT_CYC(20), .FILTER_CYC(5)) dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(), .crosscouple_done_i(ev[0]),
    .crosscouple_aborted_i(ev[1]), .crosscouple_running_i(run), .trim_crc_fail_i(trim),
    .sensor_read_fault_i(ev[2]), .clock_fault_reset_i(ev[7]), .soft_reset_i(ev[8]),
    .supply_reg_undervolt_i(ev[3]), .supply_reg_overvolt_i(ov),
    .supply_reg_deep_undervolt_i(ev[14]), .supply_reg_enable_bit_i(en_bit),
    .supply_reg_enable_wr_i(en_wr), .supply_reg_active_i(supply_reg_active), .supply_reg_off_o(),
    .sync_pin_i(pin), .sync_pin_source_i(src), .sync_slow_i({2{ev[4]}}),
    .sync_low_level_i({2{ev[5]}}), .upbuf_write_i({2{ev[6]}}), .upbuf_pending_i(pend),
    .ch_enable_bit_i(chen), .ch_enable_wr_i(ch_wr), .crosscouple_result_i({2{ev[9]}}),
    .buffer_empty_fault_i({2{ev[10]}}), .open_load_i({2{ev[11]}}),
    .short_battery_i({2{ev[12]}}), .ground_leakage_i({2{ev[13]}}),
    .short_ground_i({2{ev[15]}}), .overtemp_i({2{ev[16]}}), .line_undervolt_i(uv),
    .xct_ground_result_i(xg), .selftest_write_allowed_i(sel), .sensor_init_ready_i(init),
    .fifo_full_i(full), .fifo_empty_i(empty), .fifo_read_i(fread),
    .global_fault_summary_o(sum));
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] frame(input logic w, input logic [5:0] a);
    logic [31:0] f;
    logic [2:0]  c;
    f = {w, a, 16'hFFFF, 9'h000};
    c = CRC_SEED;
    for (int i = 31; i >= 3; i--) c = {c[1:0], 1'b0} ^ ((c[2] ^ f[i]) ? CRC_POLY : 3'h0);
    return {f[31:3], c};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // read, then a write frame to fetch the answer; that write must change nothing
  task automatic chk(input logic [5:0] a, input logic [15:0] e);
    logic [31:0] rx;
    host.xfer(frame(1'b0, a), rx);
    host.xfer(frame(1'b1, 6'h04), rx);
    `CHK($sformatf("reg %h", a), e, rx[31:16])
  endtask
  task results;
    $display("checked %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk_i);
    err_total++;
    results();
  end
  initial begin
    logic [31:0] rx;
    logic [15:0] e;
    logic [5:0]  a;
    {run, trim, ov, sel, init, supply_reg_active, en_bit, en_wr, ch_wr, full, empty, fread} = '0;
    {pin, src, pend, chen, uv, xg, ev} = '0;
    lf = 16'hAD5A;
    reset_n_i = 1'b0;
    tick(12);
    reset_n_i = 1'b1;
    tick(3);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      {run, trim, ov, sel, init, supply_reg_active, en_bit, uv, pend, chen} = lf[12:0];
      e = {sel, init, supply_reg_active, 4'h0, pend[1], chen[1], 2'h0, pend[0], chen[0], 2'h0, i == 0};
      chk(6'h06, e);
      chk(6'h04, {2'h0, run, 1'b0, trim, 1'b0, ov, 9'h000});
      chk(6'h05, run ? 16'h0000 : {7'h00, uv[1], 7'h00, uv[0]});
    end
    {run, trim, ov, sel, init, supply_reg_active, en_bit, uv, pend, chen} = '0;
    {run, xg, ev[12]} = 4'hB;
    tick(1);
    ev[12] = 1'b0;
    tick(6);
    `CHK("summary", 1'b0, sum)
    chk(6'h05, 16'h1011);
    {run, xg, uv} = 5'h01;
    tick(6);
    `CHK("summary", 1'b1, sum)
    chk(6'h05, 16'h0001);
    {uv, src, pin} = 6'h0B;
    tick(40);
    pin = 2'b00;
    chk(6'h04, 16'h0080);
    chk(6'h06, 16'h0220);
    {src, full, fread} = 4'h3;
    tick(1);
    {full, fread} = 2'b00;
    chk(6'h06, 16'h1000);
    empty = 1'b1;
    chk(6'h06, 16'h0000);
    empty = 1'b0;
    host.xfer(frame(1'b0, 6'h04) ^ 32'h1, rx);
    chk(6'h04, 16'h1000);
    host.xfer(frame(1'b0, 6'h20), rx);
    chk(6'h04, 16'h1000);
    chk(6'h10, 16'h0000);
    pend = 2'b11;
    for (int k = 0; k < 17; k++) begin
      a = {2'b00, tbl[k][19:16]};
      e = tbl[k][15:0] | keep[a[2:0]] | ((a == 6'h06) ? 16'h0110 : 16'h0000);
      ev[k] = 1'b1;
      tick(1);
      ev[k] = 1'b0;
      chk(a, e);
      if (tbl[k][20]) keep[a[2:0]] |= tbl[k][15:0];
      chk(a, tbl[k][20] ? e : e & ~tbl[k][15:0]);
    end
    {en_wr, ch_wr} = 2'b11;
    tick(1);
    {en_wr, ch_wr} = 2'b00;
    chk(6'h04, 16'h0000);
    chk(6'h05, 16'h0000);
    results();
  end
endmodule
